// ---- logic/lzr_map.svh ----
`ifndef LZR_MAP_SVH
`define LZR_MAP_SVH

// Register offsets on the internal register port.
`define LZR_ADDR_SENSE_CFG 8'h20
`define LZR_ADDR_RAMP_RATE 8'h30
`define LZR_ADDR_ZONE_INFO 8'h40

// Reset values of the stored bits.
`define LZR_RST_SENSE_CFG 7'h2c
`define LZR_RST_RAMP_RATE 6'h00
`define LZR_RST_ZONE_CODE 3'h0

// Field positions of the sensing configuration register.
`define LZR_SEL_HI 6
`define LZR_SEL_LO 5
`define LZR_MODE_BIT 4
`define LZR_EN_BIT 3
`define LZR_AVG_HI 2
`define LZR_AVG_LO 0

// Field positions of the ramp-rate register.
`define LZR_RISE_HI 5
`define LZR_RISE_LO 3
`define LZR_FALL_HI 2
`define LZR_FALL_LO 0

// Field position of the zone-change flag in the zone information register.
`define LZR_FLAG_BIT 3

// Timing: clock rate, sensor sample interval and averaging base period.
`define LZR_CLK_HZ 10000000
`define LZR_SAMPLE_US 1000
`define LZR_SAMPLE_CYC (`LZR_SAMPLE_US * (`LZR_CLK_HZ / 1000000))
`define LZR_AVG_BASE_MS 32
`define LZR_AVG_BASE_SAMPLES (`LZR_AVG_BASE_MS * 1000 / `LZR_SAMPLE_US)

// Timing: ramp step times for code 000 and for code 001.
`define LZR_FAST_STEP_NS 8000
`define LZR_FAST_STEP_CYC (`LZR_FAST_STEP_NS * (`LZR_CLK_HZ / 1000000) / 1000)
`define LZR_SLOW_STEP_NS 1024000
`define LZR_SLOW_STEP_CYC (`LZR_SLOW_STEP_NS * (`LZR_CLK_HZ / 1000000) / 1000)

`endif

// ---- logic/lzr_pkg.sv ----
package lzr_pkg;
  // Direction of the brightness ramp, one-hot.
  typedef enum logic [2:0] {
    RAMP_HOLD = 3'b001,
    RAMP_UP = 3'b010,
    RAMP_DOWN = 3'b100
  } lzr_ramp_e;
  typedef logic [7:0] lzr_byte_t;
  typedef logic [6:0] lzr_code_t;
  typedef logic [2:0] lzr_zone_t;
  typedef logic [2:0] lzr_sel_t;
endpackage : lzr_pkg

// ---- logic/lzr_step_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carries the ramp settings to the ramp engine and its level back.
interface lzr_step_if;
  import lzr_pkg::*;
  lzr_sel_t rise_sel;
  lzr_sel_t fall_sel;
  lzr_code_t target;
  lzr_code_t level;
  logic busy;
  modport regs (output rise_sel, output fall_sel, output target,
    input level, input busy);
  modport ramp (input rise_sel, input fall_sel, input target,
    output level, output busy);
endinterface : lzr_step_if
`default_nettype wire

// ---- logic/lzr_ramp.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lzr_map.svh"
module lzr_ramp #(
  parameter int unsigned FAST_STEP_CYC = `LZR_FAST_STEP_CYC, // Code 000.
  parameter int unsigned SLOW_STEP_CYC = `LZR_SLOW_STEP_CYC  // Code 001.
) (
  input wire logic clk,   // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  lzr_step_if.ramp step   // Settings in, level out.
);
  import lzr_pkg::*;

  localparam int CNT_W = 24;

  // The slowest code shifts the base by six, which must fit the counter.
  if (FAST_STEP_CYC < 1 || SLOW_STEP_CYC < 1 ||
      SLOW_STEP_CYC > (1 << (CNT_W - 7))) begin : g_bad
    $error("lzr_ramp: step cycle counts out of range");
  end

  // Cycles per brightness step for one 3-bit code.
  function automatic logic [CNT_W-1:0] step_len(input lzr_sel_t sel);
    logic [CNT_W-1:0] len;
    len = CNT_W'(SLOW_STEP_CYC);
    if (sel == 3'h0) begin
      step_len = CNT_W'(FAST_STEP_CYC);
    end else begin
      step_len = len << (sel - 3'h1);
    end
  endfunction

  lzr_ramp_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  lzr_code_t level_q, level_d;
  logic [CNT_W-1:0] len;

  // Each direction uses its own field, so rise and fall are independent.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    level_d = level_q;
    len = step_len(step.rise_sel);
    if (step.target == level_q) begin
      state_d = RAMP_HOLD;
      cnt_d = '0;
    end else begin
      if (step.target > level_q) begin
        state_d = RAMP_UP;
      end else begin
        state_d = RAMP_DOWN;
        len = step_len(step.fall_sel);
      end
      // A reversal restarts the step timer so no step comes early.
      if (state_d != state_q) begin
        cnt_d = '0;
      end else if (cnt_q >= len - 1'b1) begin
        cnt_d = '0;
        case (state_q)
          RAMP_UP: level_d = level_q + 7'h01;
          RAMP_DOWN: level_d = level_q - 7'h01;
          default: level_d = level_q;
        endcase
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Ramp state registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RAMP_HOLD;
      cnt_q <= '0;
      level_q <= 7'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign step.level = level_q;
  assign step.busy = (state_q != RAMP_HOLD);
endmodule // lzr_ramp
`default_nettype wire

// ---- logic/lzr_regs.sv ----
// Summary of operation
// - Sensing config register holds input select, mode, enable, averaging.
// - Ramp-rate register sets LED step speed for rising and falling.
// - Bits 5:3 set rise step, bits 2:0 fall step, independently.
// - Ramp-rate register sits at 0x30, resets to 0x00, bits 7:6 unused.
// - Zone register is read-only and rewritten when the zone changes.
// - A zone register update pulls the open-drain interrupt low.
// - Host reads the zone register; that read releases the interrupt.
// - Zone-change flag in bit 3 sets on change, clears on read.
// - Flag reads 1 after a crossing into a new zone, else 0.
`timescale 1ns/1ps
`default_nettype none
`include "lzr_map.svh"
module lzr_regs #(
  parameter int unsigned SAMPLE_CYC = `LZR_SAMPLE_CYC,       // Per sample.
  parameter int unsigned AVG_BASE = `LZR_AVG_BASE_SAMPLES,   // Code 000.
  parameter int unsigned FAST_STEP_CYC = `LZR_FAST_STEP_CYC, // Step 000.
  parameter int unsigned SLOW_STEP_CYC = `LZR_SLOW_STEP_CYC  // Step 001.
) (
  input wire logic CLK,                     // System clock, 10 MHz.
  input wire logic RST_N,                   // Asynchronous reset.
  input wire lzr_pkg::lzr_byte_t REG_ADDR,  // Register offset.
  input wire lzr_pkg::lzr_byte_t REG_WDATA, // Write data.
  input wire logic REG_WR,                  // Write strobe, one cycle.
  input wire logic REG_RD,                  // Read strobe, one cycle.
  output lzr_pkg::lzr_byte_t REG_RDATA,     // Read data, next cycle.
  input wire lzr_pkg::lzr_byte_t LIGHT_INPUT_ONE, // First sensor level.
  input wire lzr_pkg::lzr_byte_t LIGHT_INPUT_TWO, // Second sensor level.
  input wire lzr_pkg::lzr_byte_t ZONE_LIMIT_ZERO,  // Lowest boundary.
  input wire lzr_pkg::lzr_byte_t ZONE_LIMIT_ONE,   // Second boundary.
  input wire lzr_pkg::lzr_byte_t ZONE_LIMIT_TWO,   // Third boundary.
  input wire lzr_pkg::lzr_byte_t ZONE_LIMIT_THREE, // Highest boundary.
  input wire lzr_pkg::lzr_code_t TARGET_CODE, // Brightness to ramp to.
  output lzr_pkg::lzr_code_t LED_CODE,      // Ramped brightness.
  output logic RAMP_BUSY,                   // Ramp still stepping.
  output lzr_pkg::lzr_zone_t CURRENT_ZONE,  // Zone now reported.
  output logic AMBIENT_CTRL,                // Sensing sets LED current.
  output logic INT_N_O,                     // Interrupt pin level, low.
  output logic INT_N_OE                     // Interrupt pin driven.
);
  import lzr_pkg::*;

  localparam int BASE_SH = $clog2(AVG_BASE);
  localparam int SCNT_W = $clog2(SAMPLE_CYC + 1);
  localparam int NCNT_W = BASE_SH + 8;
  localparam int ACC_W = 8 + NCNT_W;

  // The average divides by shifting, so the base count must be 2**n.
  if (SAMPLE_CYC < 1 || AVG_BASE < 1 ||
      (1 << BASE_SH) != AVG_BASE) begin : g_bad
    $error("lzr_regs: sample timing parameters out of range");
  end

  // Picks the sensor value that drives the zone logic.
  function automatic lzr_byte_t pick_input(input logic [1:0] sel,
      input lzr_byte_t a, input lzr_byte_t b);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    case (sel)
      2'b00: pick_input = sum[8:1];
      2'b01: pick_input = a;
      2'b10: pick_input = b;
      default: pick_input = (a > b) ? a : b;
    endcase
  endfunction

  // Counts how many boundaries the value has reached; at most four.
  function automatic lzr_zone_t zone_of(input lzr_byte_t v,
      input lzr_byte_t z0, input lzr_byte_t z1, input lzr_byte_t z2,
      input lzr_byte_t z3);
    zone_of = 3'h0;
    if (v >= z0) zone_of = 3'h1;
    if (v >= z1) zone_of = 3'h2;
    if (v >= z2) zone_of = 3'h3;
    if (v >= z3) zone_of = 3'h4;
  endfunction

  logic [6:0] cfg_q, cfg_d;
  logic [5:0] ramp_q, ramp_d;
  lzr_byte_t rdata_q, rdata_d;
  logic wr_cfg, wr_ramp, rd_zone;

  assign wr_cfg = REG_WR && (REG_ADDR == `LZR_ADDR_SENSE_CFG);
  assign wr_ramp = REG_WR && (REG_ADDR == `LZR_ADDR_RAMP_RATE);
  assign rd_zone = REG_RD && (REG_ADDR == `LZR_ADDR_ZONE_INFO);

  logic [2:0] zone_q, zone_d;
  logic flag_q, flag_d;
  logic int_q, int_d;

  // Host register writes and registered read data. Unused bits and
  // unmapped offsets read as zero; the zone register ignores writes.
  always_comb begin
    cfg_d = cfg_q;
    ramp_d = ramp_q;
    rdata_d = rdata_q;
    if (wr_cfg) begin
      cfg_d = REG_WDATA[6:0];
    end
    if (wr_ramp) begin
      ramp_d = REG_WDATA[5:0];
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `LZR_ADDR_SENSE_CFG: rdata_d = {1'b0, cfg_q};
        `LZR_ADDR_RAMP_RATE: rdata_d = {2'b00, ramp_q};
        `LZR_ADDR_ZONE_INFO: rdata_d = {4'h0, flag_q, zone_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register file storage.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= `LZR_RST_SENSE_CFG;
      ramp_q <= `LZR_RST_RAMP_RATE;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      ramp_q <= ramp_d;
      rdata_q <= rdata_d;
    end
  end

  logic sense_en;
  logic [2:0] avg_sel;
  logic [SCNT_W-1:0] scnt_q, scnt_d;
  logic [NCNT_W-1:0] ncnt_q, ncnt_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [ACC_W-1:0] acc_sum;
  logic [NCNT_W-1:0] n_last;
  lzr_byte_t avg_val;
  lzr_zone_t new_zone;
  logic period_done;

  assign sense_en = cfg_q[`LZR_EN_BIT];
  assign avg_sel = cfg_q[`LZR_AVG_HI:`LZR_AVG_LO];

  // Averaging: one sample per interval, AVG_BASE << code samples per
  // period, so 000 gives the base period and each code doubles it.
  always_comb begin
    scnt_d = scnt_q;
    ncnt_d = ncnt_q;
    acc_d = acc_q;
    period_done = 1'b0;
    n_last = NCNT_W'(AVG_BASE - 1) << avg_sel;
    n_last = n_last | ((NCNT_W'(1) << avg_sel) - NCNT_W'(1));
    acc_sum = acc_q + ACC_W'(pick_input(cfg_q[`LZR_SEL_HI:`LZR_SEL_LO],
      LIGHT_INPUT_ONE, LIGHT_INPUT_TWO));
    avg_val = 8'(acc_sum >> (BASE_SH + int'(avg_sel)));
    new_zone = zone_of(avg_val, ZONE_LIMIT_ZERO, ZONE_LIMIT_ONE,
      ZONE_LIMIT_TWO, ZONE_LIMIT_THREE);
    if (!sense_en || wr_cfg) begin
      // A disabled or reconfigured sensor starts a fresh period.
      scnt_d = '0;
      ncnt_d = '0;
      acc_d = '0;
    end else if (scnt_q == SCNT_W'(SAMPLE_CYC - 1)) begin
      scnt_d = '0;
      if (ncnt_q >= n_last) begin
        period_done = 1'b1;
        ncnt_d = '0;
        acc_d = '0;
      end else begin
        ncnt_d = ncnt_q + 1'b1;
        acc_d = acc_sum;
      end
    end else begin
      scnt_d = scnt_q + 1'b1;
    end
  end

  // Averaging registers.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scnt_q <= '0;
      ncnt_q <= '0;
      acc_q <= '0;
    end else begin
      scnt_q <= scnt_d;
      ncnt_q <= ncnt_d;
      acc_q <= acc_d;
    end
  end

  // Zone report and interrupt. A new zone sets the flag and the
  // interrupt; a read of the zone register clears both, but a zone
  // change in the same cycle wins so the event is never lost.
  always_comb begin
    zone_d = zone_q;
    flag_d = flag_q;
    int_d = int_q;
    if (rd_zone) begin
      flag_d = 1'b0;
      int_d = 1'b0;
    end
    if (period_done && new_zone != zone_q) begin
      zone_d = new_zone;
      flag_d = 1'b1;
      int_d = 1'b1;
    end
  end

  // Zone registers.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      zone_q <= `LZR_RST_ZONE_CODE;
      flag_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      zone_q <= zone_d;
      flag_q <= flag_d;
      int_q <= int_d;
    end
  end

  lzr_step_if step ();

  assign step.rise_sel = ramp_q[`LZR_RISE_HI:`LZR_RISE_LO];
  assign step.fall_sel = ramp_q[`LZR_FALL_HI:`LZR_FALL_LO];
  assign step.target = TARGET_CODE;

  // Ramp engine steps the LED code toward the target.
  lzr_ramp #(
    .FAST_STEP_CYC(FAST_STEP_CYC),
    .SLOW_STEP_CYC(SLOW_STEP_CYC)
  ) u_ramp (
    .clk(CLK),
    .rst_n(RST_N),
    .step(step)
  );

  // Open-drain pin: only ever driven low, released otherwise.
  assign INT_N_O = 1'b0;
  assign INT_N_OE = int_q;
  assign REG_RDATA = rdata_q;
  assign LED_CODE = step.level;
  assign RAMP_BUSY = step.busy;
  assign CURRENT_ZONE = zone_q;
  assign AMBIENT_CTRL = cfg_q[`LZR_MODE_BIT] && cfg_q[`LZR_EN_BIT];
endmodule // lzr_regs
`default_nettype wire

// ---- tb/lzr_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module lzr_chk (
  input wire logic CLK, // Clock.
  input wire logic RST_N, // Reset.
  input wire lzr_pkg::lzr_byte_t REG_ADDR, // Offset.
  input wire lzr_pkg::lzr_byte_t REG_WDATA, // Write data.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  input wire lzr_pkg::lzr_byte_t REG_RDATA, // Read data.
  input wire lzr_pkg::lzr_code_t LED_CODE, // Ramped level.
  input wire lzr_pkg::lzr_zone_t CURRENT_ZONE, // Zone.
  input wire logic AMBIENT_CTRL, // Sensing control.
  input wire logic INT_N_O, // Pin level.
  input wire logic INT_N_OE // Pin driven.
);
  import lzr_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A host read of the zone register, the acknowledge of an event.
  sequence zone_read;
    REG_RD && REG_ADDR == 8'h40;
  endsequence
  // The open-drain pin may only ever pull low.
  chk_pin_drive_low: assert property (INT_N_O == 1'b0)
    else $error("interrupt drive level not low");
  chk_zone_raises_int: assert property (
    $changed(CURRENT_ZONE) |-> INT_N_OE)
    else $error("zone update without interrupt");
  // A pending event survives anything but the zone read.
  chk_int_held: assert property (
    INT_N_OE && !(REG_RD && REG_ADDR == 8'h40) |=> INT_N_OE)
    else $error("interrupt dropped without read");
  chk_read_releases: assert property (
    zone_read |=> !INT_N_OE || $changed(CURRENT_ZONE))
    else $error("zone read left interrupt pending");
  chk_zone_read_data: assert property (
    zone_read |=> REG_RDATA == {4'h0, $past(INT_N_OE), $past(CURRENT_ZONE)})
    else $error("zone read data wrong");
  chk_zone_in_range: assert property (CURRENT_ZONE <= 3'h4)
    else $error("zone code above four");
  // The ramp moves one code per step, never jumps.
  chk_ramp_one_step: assert property ($changed(LED_CODE) |->
    LED_CODE == $past(LED_CODE) + 7'h01 ||
    LED_CODE + 7'h01 == $past(LED_CODE))
    else $error("brightness jumped");
  chk_ambient_follows: assert property (REG_WR && REG_ADDR == 8'h20 |=>
    AMBIENT_CTRL == ($past(REG_WDATA[4]) && $past(REG_WDATA[3])))
    else $error("sensing control wrong");
  chk_ramp_unused: assert property (REG_RD && REG_ADDR == 8'h30 |=>
    REG_RDATA[7:6] == 2'b00)
    else $error("ramp unused bits set");
  chk_rdata_stands: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");
endmodule // lzr_chk
bind lzr_regs lzr_chk u_chk (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .LED_CODE(LED_CODE), .CURRENT_ZONE(CURRENT_ZONE),
  .AMBIENT_CTRL(AMBIENT_CTRL), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE));
`default_nettype wire

// ---- tb/lzr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module lzr_host (
  input wire logic int_o, // Device drive level.
  input wire logic int_oe, // Device drives the line.
  output logic int_pin // Resolved line level.
);
  // The host only listens; once freed, the pull-up alone sets the line.
  assign int_pin = int_oe ? int_o : 1'b1;
endmodule // lzr_host
`default_nettype wire

// ---- tb/test_light_zone_ramp_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_light_zone_ramp_regs;
  import lzr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  lzr_byte_t addr = 8'h00;
  lzr_byte_t wdata = 8'h00;
  lzr_byte_t in_one = 8'h00;
  lzr_byte_t in_two = 8'h00;
  lzr_code_t target = 7'h00;
  lzr_byte_t lim0 = 8'h33;
  lzr_byte_t lim1 = 8'h66;
  lzr_byte_t lim2 = 8'h99;
  lzr_byte_t lim3 = 8'hcc;
  lzr_byte_t rdata, got;
  lzr_code_t led;
  lzr_zone_t zone, ez, prev;
  logic busy, amb, int_o, int_oe, int_pin;
  lzr_zone_t zt[4] = '{3'h2, 3'h1, 3'h4, 3'h4};
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int c;
  // Counts are shortened so the averaging and ramp waits stay brief.
  lzr_regs #(.SAMPLE_CYC(4), .AVG_BASE(2), .FAST_STEP_CYC(3),
    .SLOW_STEP_CYC(20)) DUT (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .LIGHT_INPUT_ONE(in_one), .LIGHT_INPUT_TWO(in_two),
    .ZONE_LIMIT_ZERO(lim0), .ZONE_LIMIT_ONE(lim1), .ZONE_LIMIT_TWO(lim2),
    .ZONE_LIMIT_THREE(lim3), .TARGET_CODE(target), .LED_CODE(led),
    .RAMP_BUSY(busy), .CURRENT_ZONE(zone), .AMBIENT_CTRL(amb),
    .INT_N_O(int_o), .INT_N_OE(int_oe));
  lzr_host host (.int_o(int_o), .int_oe(int_oe), .int_pin(int_pin));
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A hang counts as a failure and ends the run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes rise on one falling edge and drop on the next, so back to back
  // calls never assign a strobe twice in one time step.
  task automatic wr_reg(input lzr_byte_t a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input lzr_byte_t a, output lzr_byte_t d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic rd_chk(input lzr_byte_t a, e);
    rd_reg(a, got);
    check($sformatf("reg %h", a), got, e);
  endtask
  // Moves the target and counts cycles until the level arrives.
  task automatic ramp_to(input lzr_code_t t, output int n);
    @(negedge clk);
    target = t;
    n = 0;
    while (led !== t && n < 500) begin
      @(negedge clk);
      n++;
    end
  endtask
  function automatic int step_len(input int k);
    return k == 0 ? 3 : 20 << (k - 1);
  endfunction
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h20, 8'h2c);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h40, 8'h00);
    rd_chk(8'h50, 8'h00);
    wr_reg(8'h30, 8'hff);
    rd_chk(8'h30, 8'h3f);
    wr_reg(8'h20, 8'hff);
    rd_chk(8'h20, 8'h7f);
    check("ambient ctrl", {7'h0, amb}, 8'h01);
    wr_reg(8'h40, 8'hff);
    rd_chk(8'h40, 8'h00);
    // Inputs sit in different zones, so select codes 0 to 2 each give their own zone and code 3 repeats zone 4.
    in_one = 8'h40;
    in_two = 8'hd0;
    prev = 3'h0;
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h20, 8'(s << 5) | 8'h08);
      repeat (40) @(negedge clk);
      ez = zt[s];
      check("int pin", {7'h0, int_pin}, {7'h0, ez == prev});
      rd_chk(8'h40, {4'h0, ez != prev, ez});
      check("int release", {7'h0, int_pin}, 8'h01);
      check("zone", {5'h0, zone}, {5'h0, ez});
      prev = ez;
    end
    // Averaging code 3 needs sixteen samples before the zone may move.
    wr_reg(8'h20, 8'h2b);
    repeat (50) @(negedge clk);
    check("avg early", {7'h0, int_pin}, 8'h01);
    repeat (30) @(negedge clk);
    check("avg done", {7'h0, int_pin}, 8'h00);
    rd_chk(8'h40, 8'h09);
    // Mode without enable, then enable without mode, leave control off.
    wr_reg(8'h20, 8'h10);
    check("ambient off", {7'h0, amb}, 8'h00);
    // Raising the lowest boundary above the input drops it to zone 0.
    lim0 = 8'h50;
    wr_reg(8'h20, 8'h28);
    check("ambient mode", {7'h0, amb}, 8'h00);
    repeat (40) @(negedge clk);
    check("zone low", {5'h0, zone}, 8'h00);
    rd_chk(8'h40, 8'h08);
    // Rise takes codes 0, 1, 2 while fall takes 2, 1, 0, to show the fields act apart.
    for (int k = 0; k < 3; k++) begin
      wr_reg(8'h30, 8'((k << 3) | (2 - k)));
      ramp_to(7'h02, c);
      check("rise time", {7'h0, c >= 2 * step_len(k) &&
        c <= 2 * step_len(k) + 2}, 8'h01);
      check("ramp busy", {7'h0, busy}, 8'h01);
      check("led rise", {1'b0, led}, 8'h02);
      ramp_to(7'h00, c);
      check("fall time", {7'h0, c >= 2 * step_len(2 - k) &&
        c <= 2 * step_len(2 - k) + 2}, 8'h01);
      @(negedge clk);
      check("ramp idle", {7'h0, busy}, 8'h00);
    end
    report_and_stop();
  end
endmodule // test_light_zone_ramp_regs
`default_nettype wire
